/* src/pwd_pkg.sv */
/*
  constants and carrier types for the supervision block of a four-port power controller.
  assumes the serial interface front end delivers decoded register reads and writes on clk.
*/
package pwd_pkg;
  localparam logic [7:0] ADDR_PUSH    = 8'h1A;
  localparam logic [7:0] ADDR_ID      = 8'h1B;
  localparam logic [7:0] ADDR_FLAGS   = 8'h1C;
  localparam logic [7:0] ADDR_WDOG    = 8'h1E;
  localparam logic [7:0] ADDR_SWMODE  = 8'h1F;
  localparam logic [7:0] ADDR_PROG    = 8'h23;
  localparam logic [7:0] ADDR_HPRSV   = 8'h24;
  localparam logic [7:0] ADDR_RSVD    = 8'h25;
  localparam int         BIT_IRQ_CLR  = 7;
  localparam int         BIT_CHIP_RST = 4;
  localparam int         BIT_WD_EN    = 7;
  localparam int         BIT_WD_IRQ   = 6;
  localparam int         BIT_LARGE_C  = 5;
  localparam int         BIT_DETECTION_BYPASS_ALLOW   = 4;
  localparam int         BIT_OSC_MSK  = 3;
  localparam logic [7:0] RST_FLAGS    = 8'h00;
  localparam logic [7:0] RST_WDOG     = 8'h00;
  localparam logic [7:0] RST_SWMODE   = 8'h00;
  localparam logic [7:0] RST_PROG     = 8'h04;
  localparam logic [7:0] SWMODE_WMASK = 8'hDF;
  localparam logic [7:0] PROG_WMASK   = 8'h3F;
  localparam logic [1:0] MODE_SHUT    = 2'h0;
  localparam logic [1:0] MODE_AUTO    = 2'h3;
  localparam int         CLK_HZ       = 50000000;
  localparam int         TICK_MS      = 164;
  localparam int         TICK_CYC     = (CLK_HZ / 1000) * TICK_MS;
  localparam int         NPORT        = 4;
  // analog threshold in nano-amps: base plus step per code
  localparam int         AC_BASE_NA   = 226680;
  localparam int         AC_STEP_NA   = 28330;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwd_req_t;

  typedef struct packed {
    logic       large_cap;
    logic       det_bypass;
    logic       osc_mask;
    logic [2:0] ac_thresh;
  } pwd_prog_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HW   = 3'b100
  } pwd_state_t;
endpackage : pwd_pkg

/* src/pwd_tick.sv */
/*
  tick divider: one-cycle enable every period.
  assumes a free running clk and synchronous active-high clear.
*/
module pwd_tick #(
  parameter int PERIOD = pwd_pkg::TICK_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clear,
  output logic      tick
);
  import pwd_pkg::*;
  logic [31:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule : pwd_tick

/* src/pwd_watchdog.sv */
/*
  watchdog takeover, global pushbuttons, id and program registers.
  assumes decoded single-cycle register requests from the serial front end and
  software power-on / mode-change requests from the port controllers.
*/
module pwd_watchdog #(
  parameter int         TICK_PERIOD = pwd_pkg::TICK_CYC,
  parameter logic [4:0] DEV_CODE    = 5'h05, // arbitrary value
  parameter logic [2:0] REV_CODE    = 3'h1   // arbitrary value
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire pwd_pkg::pwd_req_t           req,
  input  wire logic [3:0]                  pwr_on_req,
  input  wire logic [3:0]                  mode_chg_req,
  input  wire logic [7:0]                  mode_chg_val,
  input  wire logic                        oscillator_failure_flag_in,
  output logic [7:0]                       rdata,
  output logic                             rvalid,
  output logic [7:0]                       port_mode,
  output logic [3:0]                       port_pwr_on,
  output logic [3:0]                       port_soft_rst,
  output logic                             irq_clear,
  output logic                             wd_irq,
  output logic                             hw_control,
  output pwd_pkg::pwd_prog_t               prog_out,
  output logic                             oscillator_failure_flag
);
  import pwd_pkg::*;

  logic [7:0] hw_control_flag_reg;
  logic [7:0] watchdog_count_reg;
  logic [7:0] switch_mode_reg;
  logic [7:0] program_reg;
  logic       chip_rst_reg;
  logic       tick;
  logic       rst_all;
  logic       wr_push;
  logic       wr_wdog;
  logic       wr_swmode;
  logic       wr_prog;
  logic       rd_flags;
  logic       wd_en;
  logic       expiry;
  logic [3:0] refused;
  logic [7:0] flags_next;
  logic [2:0] osc_sync_reg;
  pwd_state_t state_reg;

  // chip reset button acts one cycle later as a full synchronous reset
  assign rst_all   = sys_rst || chip_rst_reg;
  assign wr_push   = req.wr && req.addr == ADDR_PUSH;
  assign wr_wdog   = req.wr && req.addr == ADDR_WDOG;
  assign wr_swmode = req.wr && req.addr == ADDR_SWMODE;
  assign wr_prog   = req.wr && req.addr == ADDR_PROG;
  assign rd_flags  = req.rd && req.addr == ADDR_FLAGS;
  assign wd_en     = switch_mode_reg[BIT_WD_EN];
  // entry into hardware control happens once, when the count first hits zero
  assign expiry    = state_reg == ST_RUN && watchdog_count_reg == 8'h00 && !wr_wdog;
  assign refused   = (state_reg == ST_HW) ? pwr_on_req : 4'h0;

  pwd_tick #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .clk     (clk),
    .sys_rst (rst_all),
    .clear   (!wd_en),
    .tick    (tick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chip_rst_reg <= 1'b0;
    end else begin
      chip_rst_reg <= wr_push && req.wdata[BIT_CHIP_RST];
    end
  end

  // pushbuttons are pulses; nothing is stored, so they read back as cleared
  always_ff @(posedge clk) begin
    if (rst_all) begin
      irq_clear     <= 1'b0;
      port_soft_rst <= 4'h0;
    end else begin
      irq_clear     <= wr_push && req.wdata[BIT_IRQ_CLR];
      port_soft_rst <= wr_push ? req.wdata[3:0] : 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (wd_en) state_reg <= ST_RUN;
        ST_RUN: begin
          if (!wd_en) state_reg <= ST_IDLE;
          else if (expiry) state_reg <= ST_HW;
        end
        // leave takeover only by disabling, by a nonzero reload or by a reset
        ST_HW: begin
          if (!wd_en) state_reg <= ST_IDLE;
          else if (wr_wdog && req.wdata != 8'h00) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      watchdog_count_reg <= RST_WDOG;
    end else if (wr_wdog) begin
      watchdog_count_reg <= req.wdata;
    end else if (wd_en && tick && watchdog_count_reg != 8'h00) begin
      watchdog_count_reg <= watchdog_count_reg - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      switch_mode_reg <= RST_SWMODE;
    end else if (wr_swmode) begin
      switch_mode_reg <= req.wdata & SWMODE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      program_reg <= RST_PROG;
    end else if (wr_prog) begin
      program_reg <= req.wdata & PROG_WMASK;
    end
  end

  // set wins over the clear-on-read in the same cycle
  always_comb begin
    flags_next = rd_flags ? 8'h00 : hw_control_flag_reg;
    if (wd_en) begin
      if (expiry) flags_next[3:0] = 4'hF;
      flags_next[3:0] = flags_next[3:0] | refused;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      hw_control_flag_reg <= RST_FLAGS;
    end else begin
      hw_control_flag_reg <= flags_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      wd_irq <= 1'b0;
    end else begin
      wd_irq <= switch_mode_reg[BIT_WD_IRQ] && (|flags_next[3:0]) && wd_en;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      always_ff @(posedge clk) begin
        if (rst_all) begin
          port_mode[2*gi+:2]  <= MODE_SHUT;
          port_pwr_on[gi]     <= 1'b0;
        end else if (expiry && wd_en) begin
          port_mode[2*gi+:2]  <= switch_mode_reg[gi] ? MODE_AUTO : MODE_SHUT;
          port_pwr_on[gi]     <= 1'b0;
        end else begin
          if (mode_chg_req[gi] && state_reg != ST_HW) begin
            port_mode[2*gi+:2] <= mode_chg_val[2*gi+:2];
          end
          // a power-on request becomes a pulse only outside takeover
          port_pwr_on[gi] <= pwr_on_req[gi] && state_reg != ST_HW && !port_soft_rst[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst_all) begin
      hw_control <= 1'b0;
      prog_out   <= '0;
    end else begin
      hw_control <= state_reg == ST_HW || expiry;
      prog_out   <= '{large_cap:  program_reg[BIT_LARGE_C],
                      det_bypass: program_reg[BIT_DETECTION_BYPASS_ALLOW],
                      osc_mask:   program_reg[BIT_OSC_MSK],
                      ac_thresh:  program_reg[2:0]};
    end
  end

  // external failure pin: three stages, accept when last two agree
  always_ff @(posedge clk) begin
    if (rst_all) begin
      osc_sync_reg            <= 3'h0;
      oscillator_failure_flag <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], oscillator_failure_flag_in};
      if (osc_sync_reg[2] == osc_sync_reg[1]) begin
        oscillator_failure_flag <= osc_sync_reg[2] && !program_reg[BIT_OSC_MSK];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      case (req.addr)
        ADDR_ID:     rdata <= {DEV_CODE, REV_CODE};
        ADDR_FLAGS:  rdata <= hw_control_flag_reg;
        ADDR_WDOG:   rdata <= watchdog_count_reg;
        ADDR_SWMODE: rdata <= switch_mode_reg;
        ADDR_PROG:   rdata <= program_reg;
        default:     rdata <= 8'h00;
      endcase
    end
  end

  wdog_reload_a: assert property (@(posedge clk) disable iff (rst_all)
    wr_wdog |=> watchdog_count_reg == $past(req.wdata)) else $error("count not loaded");
  wdog_hold_a: assert property (@(posedge clk) disable iff (rst_all)
    watchdog_count_reg == 8'h00 && !wr_wdog |=> watchdog_count_reg == 8'h00) else $error("count wrapped");
  wdog_dec_a: assert property (@(posedge clk) disable iff (rst_all)
    wd_en && tick && !wr_wdog && watchdog_count_reg != 8'h00 |=>
      watchdog_count_reg == $past(watchdog_count_reg) - 8'h01) else $error("no decrement");
  wdog_idle_a: assert property (@(posedge clk) disable iff (rst_all)
    !wd_en && !wr_wdog |=> $stable(watchdog_count_reg)) else $error("count moved");
  expiry_flag_a: assert property (@(posedge clk) disable iff (rst_all)
    expiry && wd_en |=> hw_control_flag_reg[3:0] == 4'hF) else $error("flags not set");
  expiry_mode_a: assert property (@(posedge clk) disable iff (rst_all)
    expiry && wd_en && switch_mode_reg[0] |=> port_mode[1:0] == MODE_AUTO) else $error("not auto");
  expiry_shut_a: assert property (@(posedge clk) disable iff (rst_all)
    expiry && wd_en && !switch_mode_reg[1] |=> port_mode[3:2] == MODE_SHUT) else $error("not shutdown");
  // a refused request while the enable is being dropped sets no flag, so the enable is part of the cause
  refuse_pwr_a: assert property (@(posedge clk) disable iff (rst_all)
    state_reg == ST_HW && wd_en && pwr_on_req[2] |=> !port_pwr_on[2] && hw_control_flag_reg[2])
    else $error("power on leaked");
  hold_mode_a: assert property (@(posedge clk) disable iff (rst_all)
    state_reg == ST_HW && !expiry |=> $stable(port_mode)) else $error("mode changed");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst_all)
    rd_flags && !expiry && refused == 4'h0 |=> hw_control_flag_reg == 8'h00) else $error("flags kept");
  irq_gate_a: assert property (@(posedge clk) disable iff (rst_all)
    !switch_mode_reg[BIT_WD_IRQ] |=> !wd_irq) else $error("irq unmasked");
  push_pulse_a: assert property (@(posedge clk) disable iff (rst_all)
    port_soft_rst[0] && !(wr_push && req.wdata[0]) |=> !port_soft_rst[0]) else $error("button stuck");
  chip_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    chip_rst_reg |=> program_reg == RST_PROG && switch_mode_reg == 8'h00) else $error("map not reset");

  expiry_c: cover property (@(posedge clk) expiry && wd_en);
  refused_c: cover property (@(posedge clk) |refused && wd_en);
  reload_c: cover property (@(posedge clk) state_reg == ST_HW ##1 state_reg == ST_RUN);
endmodule : pwd_watchdog

/* verif/pwd_host.sv */
/*
  host software model: issues register writes and reads on the decoded request port.
  assumes the block answers a read with rvalid and rdata within a few cycles.
*/
module pwd_host (
  input  wire logic               clk,
  output pwd_pkg::pwd_req_t       req,
  input  wire logic [7:0]         rdata,
  input  wire logic               rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwd_pkg::*;

  initial req = '0;

  // request held across the sampling edge, released at the next falling edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask : read

  // keep-alive: a nonzero reload before the count runs out
  task automatic reload(input logic [7:0] cnt);
    write(ADDR_WDOG, (cnt == 8'h00) ? 8'h01 : cnt);
  endtask : reload
endmodule : pwd_host

/* verif/pwd_watchdog_test.sv */
/*
  self-checking bench for the watchdog takeover block.
  assumes a shortened tick period of 20 cycles; host model drives all register traffic.
*/
module pwd_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pwd_pkg::*;

  localparam int         TP  = 20;
  localparam logic [4:0] DEV = 5'h0A; // arbitrary value
  localparam logic [2:0] REVISION_FIELD = 3'h3;  // arbitrary value

  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  pwd_req_t   req;
  logic [3:0] pwr_on_req = 4'h0;
  logic [3:0] mode_chg_req = 4'h0;
  logic [7:0] mode_chg_val = 8'h00;
  logic       oscillator_failure_flag_in = 1'b0;
  logic [7:0] rdata;
  logic       rvalid;
  logic [7:0] port_mode;
  logic [3:0] port_pwr_on;
  logic [3:0] port_soft_rst;
  logic       irq_clear;
  logic       wd_irq;
  logic       hw_control;
  pwd_prog_t  prog_out;
  logic       oscillator_failure_flag;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] v;
  int         n;

  always #10 clk = ~clk;

  pwd_watchdog #(.TICK_PERIOD(TP), .DEV_CODE(DEV), .REV_CODE(REVISION_FIELD)) dut_u (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .req                     (req),
    .pwr_on_req              (pwr_on_req),
    .mode_chg_req            (mode_chg_req),
    .mode_chg_val            (mode_chg_val),
    .oscillator_failure_flag_in             (oscillator_failure_flag_in),
    .rdata                   (rdata),
    .rvalid                  (rvalid),
    .port_mode               (port_mode),
    .port_pwr_on             (port_pwr_on),
    .port_soft_rst           (port_soft_rst),
    .irq_clear               (irq_clear),
    .wd_irq                  (wd_irq),
    .hw_control              (hw_control),
    .prog_out                (prog_out),
    .oscillator_failure_flag (oscillator_failure_flag)
  );

  pwd_host host_u (
    .clk    (clk),
    .req    (req),
    .rdata  (rdata),
    .rvalid (rvalid)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    host_u.read(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask : rd_check

  task automatic final_report;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    check("prog_out", {2'b00, prog_out}, 8'h04);
    rd_check(ADDR_FLAGS, 8'h00);
    rd_check(ADDR_WDOG, 8'h00);
    rd_check(ADDR_SWMODE, 8'h00);
    rd_check(ADDR_PROG, 8'h04);
    rd_check(ADDR_ID, {DEV, REVISION_FIELD});
    host_u.write(ADDR_ID, 8'hFF);
    rd_check(ADDR_ID, {DEV, REVISION_FIELD});
    host_u.write(ADDR_RSVD, 8'hFF);
    rd_check(ADDR_RSVD, 8'h00);
    // program register fields and oscillator masking
    oscillator_failure_flag_in = 1'b1;
    host_u.write(ADDR_PROG, 8'hFF);
    repeat (4) @(negedge clk);
    check("prog_out", {2'b00, prog_out}, 8'h3F);
    check("osc flag", {7'h00, oscillator_failure_flag}, 8'h00);
    host_u.write(ADDR_PROG, 8'h37);
    repeat (4) @(negedge clk);
    check("osc flag", {7'h00, oscillator_failure_flag}, 8'h01);
    check("ac threshold", {5'h00, prog_out.ac_thresh}, 8'h07);
    check("bypass", {7'h00, prog_out.det_bypass}, 8'h01);
    rd_check(ADDR_PROG, 8'h37);
    oscillator_failure_flag_in = 1'b0;
    // pushbuttons pulse one cycle, then fall back by themselves
    host_u.write(ADDR_PUSH, 8'h80);
    check("irq clear", {7'h00, irq_clear}, 8'h01);
    for (int p = 0; p < NPORT; p++) begin
      host_u.write(ADDR_PUSH, 8'h01 << p);
      check("port reset", {4'h0, port_soft_rst}, 8'h01 << p);
      @(negedge clk);
      check("port reset end", {4'h0, port_soft_rst}, 8'h00);
    end
    // watchdog countdown to takeover, port 0 auto, others shutdown
    host_u.write(ADDR_WDOG, 8'h03);
    rd_check(ADDR_WDOG, 8'h03);
    host_u.write(ADDR_SWMODE, 8'hC1);
    repeat (48) @(negedge clk);
    rd_check(ADDR_WDOG, 8'h01);
    check("early takeover", {7'h00, hw_control}, 8'h00);
    n = 0;
    while (hw_control !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("hw control", {7'h00, hw_control}, 8'h01);
    check("port mode", port_mode, 8'h03);
    check("wd irq", {7'h00, wd_irq}, 8'h01);
    repeat (45) @(negedge clk);
    rd_check(ADDR_WDOG, 8'h00);
    rd_check(ADDR_FLAGS, 8'h0F);
    rd_check(ADDR_FLAGS, 8'h00);
    check("wd irq off", {7'h00, wd_irq}, 8'h00);
    // refused software requests under takeover
    pwr_on_req = 4'h4;
    @(negedge clk);
    pwr_on_req = 4'h0;
    check("power on", {4'h0, port_pwr_on}, 8'h00);
    @(negedge clk);
    rd_check(ADDR_FLAGS, 8'h04);
    mode_chg_val = 8'h55;
    mode_chg_req = 4'hF;
    @(negedge clk);
    mode_chg_req = 4'h0;
    @(negedge clk);
    check("mode locked", port_mode, 8'h03);
    // nonzero reload leaves takeover; mode changes accepted again
    host_u.reload(8'h05);
    @(negedge clk);
    check("hw released", {7'h00, hw_control}, 8'h00);
    mode_chg_val = 8'h02;
    mode_chg_req = 4'h1;
    @(negedge clk);
    mode_chg_req = 4'h0;
    @(negedge clk);
    check("mode change", port_mode, 8'h02);
    pwr_on_req = 4'h1;
    @(negedge clk);
    pwr_on_req = 4'h0;
    check("power granted", {4'h0, port_pwr_on}, 8'h01);
    // disabled watchdog does not count
    host_u.write(ADDR_SWMODE, 8'h01);
    repeat (100) @(negedge clk);
    rd_check(ADDR_WDOG, 8'h05);
    check("hw idle", {7'h00, hw_control}, 8'h00);
    // takeover with the interrupt masked, then chip soft reset restores the map
    host_u.write(ADDR_SWMODE, 8'h81);
    n = 0;
    while (hw_control !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("hw control", {7'h00, hw_control}, 8'h01);
    check("wd irq masked", {7'h00, wd_irq}, 8'h00);
    check("port mode", port_mode, 8'h03);
    host_u.reload(8'h05);
    host_u.write(ADDR_PUSH, 8'h10);
    repeat (3) @(negedge clk);
    rd_check(ADDR_SWMODE, 8'h00);
    rd_check(ADDR_WDOG, 8'h00);
    rd_check(ADDR_PROG, 8'h04);
    final_report();
  end
endmodule : pwd_watchdog_test
